// ### verilog/crsr_cfg.svh
// Purpose: constants for the column readout and address upload block
// Assumes: system clock of 250 MHz; all times in ns unless named _PS
// Notes:
// What this block does
// - Line time equals blanking plus pixel multiplexing
// - Column sync loads start block, selects first half
// - Column clock rise routes first sixteen columns
// - Column clock fall routes last sixteen columns
// - Pixel period is half column clock period
// - Frame period: overhead plus lines times line
// - Sixteen serial cells share shift clock, strobe
// - Load strobe rising edge applies addresses
// - Row start ten bits, column six bits
// - Loaded column address copied only on sync pulse
// - Line end output, suppressed when windowing
`ifndef CRSR_CFG_SVH
`define CRSR_CFG_SVH

`define CRSR_T_CLK_PS      4000
`define CRSR_CHAIN_BITS    16
`define CRSR_ROW_BITS      10
`define CRSR_COL_BITS      6
`define CRSR_ROW_LSB       0
`define CRSR_COL_LSB       10
`define CRSR_HALF_COLS     16
`define CRSR_LAST_BLOCK    6'h27
`define CRSR_ROW_RESET     10'h000
`define CRSR_COL_RESET     6'h00
`define CRSR_CNT_BITS      16
`define CRSR_BLANK_BITS    8

// pin vector positions after synchronising
`define CRSR_PIN_CCLK      0
`define CRSR_PIN_CSYNC     1
`define CRSR_PIN_HOLD      2
`define CRSR_PIN_RISO      3
`define CRSR_PINS          4

// timing figures as printed and derived cycle counts (least: round up)
`define CRSR_FRAME_OVH_NS  1000
`define CRSR_ROW_BLANK_NS  200
`define CRSR_RISO_BLANK_NS 150
`define CRSR_RISO_PULSE_NS 50
`define CRSR_PIXEL_NS      25
`define CRSR_ROW_BLANK_CYC \
    ((`CRSR_ROW_BLANK_NS * 1000 + `CRSR_T_CLK_PS - 1) / `CRSR_T_CLK_PS)
`define CRSR_RISO_BLANK_CYC \
    ((`CRSR_RISO_BLANK_NS * 1000 + `CRSR_T_CLK_PS - 1) / `CRSR_T_CLK_PS)

`endif

// ### verilog/crsr_pkg.sv
// Purpose: types shared by the column readout files
// Assumes: nothing
// Notes: constants live in crsr_cfg.svh
`include "crsr_cfg.svh"
`default_nettype none
package crsr_pkg;
    typedef enum logic {CRSR_HALF_FIRST, CRSR_HALF_LAST} crsr_half_e;
    typedef enum logic [1:0] {CRSR_COL_IDLE, CRSR_COL_SCAN} crsr_col_e;
    typedef logic [`CRSR_COL_BITS-1:0] crsr_block_t;
endpackage
`default_nettype wire

// ### verilog/crsr_addr_upload.sv
// Purpose: serial window-start address upload
// Assumes: shift clock quiet while load strobe rises
// Notes: chain on shift clock, registers on clk
`include "crsr_cfg.svh"
`default_nettype none
module crsr_addr_upload (
    // clocks and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      addrShiftClk,
    // serial pins
    input  wire logic                      addrIn,
    input  wire logic                      addrLoad,
    // applied addresses
    output logic [`CRSR_ROW_BITS-1:0]      rowStart,
    output logic [`CRSR_COL_BITS-1:0]      colStart,
    output logic                           loadPulse
);
    logic [`CRSR_CHAIN_BITS-1:0] chainReg;
    logic [`CRSR_CHAIN_BITS-1:0] chainNext;
    logic [2:0]                  loadSyncReg;
    logic [2:0]                  loadSyncNext;
    logic [`CRSR_ROW_BITS-1:0]   rowReg;
    logic [`CRSR_ROW_BITS-1:0]   rowNext;
    logic [`CRSR_COL_BITS-1:0]   colReg;
    logic [`CRSR_COL_BITS-1:0]   colNext;
    logic                        pulseReg;
    logic                        pulseNext;
    logic                        loadRise;

    // sixteen cells, one shift clock, first bit lands at A1
    always_comb begin
        chainNext = {addrIn, chainReg[`CRSR_CHAIN_BITS-1:1]};
    end

    always_ff @(posedge addrShiftClk or posedge reset) begin
        if (reset) begin
            chainReg <= 16'h0000;
        end else begin
            chainReg <= chainNext;
        end
    end

    // strobe acts as request; chain is static once shifting has stopped
    always_comb begin
        loadSyncNext = {loadSyncReg[1:0], addrLoad};
        loadRise     = loadSyncReg[1] & ~loadSyncReg[2];
        rowNext      = rowReg;
        colNext      = colReg;
        pulseNext    = loadRise;
        if (loadRise) begin
            rowNext = chainReg[`CRSR_ROW_LSB +: `CRSR_ROW_BITS];
            colNext = chainReg[`CRSR_COL_LSB +: `CRSR_COL_BITS];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loadSyncReg <= 3'h0;
            rowReg      <= `CRSR_ROW_RESET;
            colReg      <= `CRSR_COL_RESET;
            pulseReg    <= 1'b0;
        end else begin
            loadSyncReg <= loadSyncNext;
            rowReg      <= rowNext;
            colReg      <= colNext;
            pulseReg    <= pulseNext;
        end
    end

    assign rowStart  = rowReg;
    assign colStart  = colReg;
    assign loadPulse = pulseReg;

    a_load_applies_row: assert property (@(posedge clk) disable iff (reset)
        loadRise |=> rowReg == $past(chainReg[9:0]))
        else $error("row start not taken on load strobe rise");
    a_addr_held_still: assert property (@(posedge clk) disable iff (reset)
        !loadRise |=> $stable(colReg) && $stable(rowReg))
        else $error("address changed without load strobe rise");
    a_load_pulse_one: assert property (@(posedge clk) disable iff (reset)
        pulseReg |=> !pulseReg)
        else $error("load pulse longer than one cycle");
    c_load_seen: cover property (@(posedge clk) disable iff (reset)
        loadRise ##1 pulseReg);
endmodule
`default_nettype wire

// ### verilog/crsr_column_readout.sv
// Purpose: column readout sequencing and window start upload
// Assumes: column pins asynchronous, sampled on clk after two flops
// Notes: column clock up to ~40 MHz keeps each half visible
`include "crsr_cfg.svh"
`default_nettype none
module crsr_column_readout (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // address upload link
    input  wire logic                       addrShiftClk,
    input  wire logic                       addrIn,
    input  wire logic                       addrLoad,
    // column timing pins
    input  wire logic                       colClk,
    input  wire logic                       colSync,
    input  wire logic                       columnSampleHold,
    input  wire logic                       rowIsolate,
    // routing outputs
    output logic [`CRSR_COL_BITS-1:0]       colBlock,
    output logic                            colHalfLast,
    output logic                            routeValid,
    output logic                            lineEnd,
    // window start for the row path
    output logic [`CRSR_ROW_BITS-1:0]       rowStartAddr,
    output logic                            addrLoaded,
    // measured timing
    output logic                            rowIsolateMode,
    output logic                            blankTooShort,
    output logic [`CRSR_CNT_BITS-1:0]       lineCycles,
    output logic [`CRSR_BLANK_BITS-1:0]     pixelCycles
);
    logic [`CRSR_PINS-1:0]        sync1Reg;
    logic [`CRSR_PINS-1:0]        sync2Reg;
    logic [`CRSR_PINS-1:0]        sync3Reg;
    logic [`CRSR_COL_BITS-1:0]    colStart;
    logic [`CRSR_ROW_BITS-1:0]    rowStart;
    logic                         loadPulse;

    crsr_pkg::crsr_col_e          stateReg;
    crsr_pkg::crsr_col_e          stateNext;
    crsr_pkg::crsr_block_t        blockReg;
    crsr_pkg::crsr_block_t        blockNext;
    crsr_pkg::crsr_half_e         halfReg;
    crsr_pkg::crsr_half_e         halfNext;
    logic                         windowReg;
    logic                         windowNext;
    logic                         lineEndReg;
    logic                         lineEndNext;
    logic [`CRSR_CNT_BITS-1:0]    lineCntReg;
    logic [`CRSR_CNT_BITS-1:0]    lineCntNext;
    logic [`CRSR_CNT_BITS-1:0]    lineLenReg;
    logic [`CRSR_CNT_BITS-1:0]    lineLenNext;
    logic [`CRSR_BLANK_BITS-1:0]  blankCntReg;
    logic [`CRSR_BLANK_BITS-1:0]  blankCntNext;
    logic [`CRSR_BLANK_BITS-1:0]  pixCntReg;
    logic [`CRSR_BLANK_BITS-1:0]  pixCntNext;
    logic [`CRSR_BLANK_BITS-1:0]  pixLenReg;
    logic [`CRSR_BLANK_BITS-1:0]  pixLenNext;
    logic                         risoModeReg;
    logic                         risoModeNext;
    logic                         shortReg;
    logic                         shortNext;
    logic [`CRSR_ROW_BITS-1:0]    rowOutReg;
    logic                         loadedReg;
    logic                         colRise;
    logic                         colFall;
    logic                         syncHigh;
    logic                         syncTaken;
    logic                         lineSelect;
    logic [`CRSR_BLANK_BITS-1:0]  blankMin;
    logic                         risoRise;
    logic                         holdFall;
    logic                         routeValidReg;
    logic                         routeValidNext;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    crsr_addr_upload u_upload (
        .clk          (clk),
        .reset        (reset),
        .addrShiftClk (addrShiftClk),
        .addrIn       (addrIn),
        .addrLoad     (addrLoad),
        .rowStart     (rowStart),
        .colStart     (colStart),
        .loadPulse    (loadPulse)
    );

    // two flops per pin before any logic; third flop only for edges
    genvar gi;
    generate
        for (gi = 0; gi < `CRSR_PINS; gi = gi + 1) begin : g_pin
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    sync1Reg[gi] <= 1'b0;
                    sync2Reg[gi] <= 1'b0;
                    sync3Reg[gi] <= 1'b0;
                end else begin
                    sync1Reg[gi] <= (gi == `CRSR_PIN_CCLK)  ? colClk :
                                    (gi == `CRSR_PIN_CSYNC) ? colSync :
                                    (gi == `CRSR_PIN_HOLD)
                                        ? columnSampleHold : rowIsolate;
                    sync2Reg[gi] <= sync1Reg[gi];
                    sync3Reg[gi] <= sync2Reg[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        colRise   = sync2Reg[`CRSR_PIN_CCLK] & ~sync3Reg[`CRSR_PIN_CCLK];
        colFall   = ~sync2Reg[`CRSR_PIN_CCLK] & sync3Reg[`CRSR_PIN_CCLK];
        syncHigh  = sync2Reg[`CRSR_PIN_CSYNC];
        syncTaken = colRise & syncHigh;
        risoRise  = sync2Reg[`CRSR_PIN_RISO] & ~sync3Reg[`CRSR_PIN_RISO];
        holdFall  = ~sync2Reg[`CRSR_PIN_HOLD] & sync3Reg[`CRSR_PIN_HOLD];
        // new line: row isolate rises, or sample-hold falls
        lineSelect = risoRise | holdFall;
        blankMin  = risoModeReg ? 8'(`CRSR_RISO_BLANK_CYC)
                                : 8'(`CRSR_ROW_BLANK_CYC);
    end

    // column scan
    always_comb begin
        stateNext   = stateReg;
        blockNext   = blockReg;
        halfNext    = halfReg;
        windowNext  = windowReg;
        lineEndNext = 1'b0;
        case (stateReg)
            crsr_pkg::CRSR_COL_IDLE: begin
                if (syncTaken) begin
                    stateNext  = crsr_pkg::CRSR_COL_SCAN;
                    blockNext  = colStart;
                    halfNext   = crsr_pkg::CRSR_HALF_FIRST;
                    windowNext = (colStart != `CRSR_COL_RESET);
                end
            end
            crsr_pkg::CRSR_COL_SCAN: begin
                if (syncTaken) begin
                    blockNext  = colStart;
                    halfNext   = crsr_pkg::CRSR_HALF_FIRST;
                    windowNext = (colStart != `CRSR_COL_RESET);
                end else if (colRise) begin
                    halfNext = crsr_pkg::CRSR_HALF_FIRST;
                    if (blockReg == `CRSR_LAST_BLOCK) begin
                        stateNext   = crsr_pkg::CRSR_COL_IDLE;
                        lineEndNext = ~windowReg;
                    end else begin
                        blockNext = blockReg + 6'h01;
                    end
                end else if (colFall) begin
                    halfNext = crsr_pkg::CRSR_HALF_LAST;
                end
            end
            default: begin
                stateNext = crsr_pkg::CRSR_COL_IDLE;
            end
        endcase
        routeValidNext = (stateNext == crsr_pkg::CRSR_COL_SCAN);
    end

    // timing measurement
    always_comb begin
        lineCntNext  = (lineCntReg == 16'hFFFF) ? lineCntReg
                                                : lineCntReg + 16'h0001;
        lineLenNext  = lineLenReg;
        blankCntNext = (blankCntReg == 8'hFF) ? blankCntReg
                                              : blankCntReg + 8'h01;
        pixCntNext   = (pixCntReg == 8'hFF) ? pixCntReg : pixCntReg + 8'h01;
        pixLenNext   = pixLenReg;
        risoModeNext = risoModeReg;
        shortNext    = shortReg;
        if (syncTaken) begin
            // line time: blanking plus pixels/16 periods
            lineLenNext = lineCntReg;
            lineCntNext = 16'h0001;
            shortNext   = (blankCntReg < blankMin);
        end
        if (lineSelect) begin
            blankCntNext = 8'h01;
            // a hold pulse also falls low; only an isolate pulse over
            // a low sample-hold marks row-isolate mode
            risoModeNext = risoRise
                         & ~sync2Reg[`CRSR_PIN_HOLD];
        end
        if (colRise | colFall) begin
            pixLenNext = pixCntReg; // each edge is one pixel
            pixCntNext = 8'h01;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stateReg    <= crsr_pkg::CRSR_COL_IDLE;
            blockReg    <= `CRSR_COL_RESET;
            halfReg     <= crsr_pkg::CRSR_HALF_FIRST;
            windowReg   <= 1'b0;
            lineEndReg  <= 1'b0;
            lineCntReg  <= 16'h0000;
            lineLenReg  <= 16'h0000;
            blankCntReg <= 8'h00;
            pixCntReg   <= 8'h00;
            pixLenReg   <= 8'h00;
            risoModeReg <= 1'b0;
            shortReg    <= 1'b0;
            rowOutReg   <= `CRSR_ROW_RESET;
            loadedReg   <= 1'b0;
            routeValidReg <= 1'b0;
        end else begin
            stateReg    <= stateNext;
            blockReg    <= blockNext;
            halfReg     <= halfNext;
            windowReg   <= windowNext;
            lineEndReg  <= lineEndNext;
            lineCntReg  <= lineCntNext;
            lineLenReg  <= lineLenNext;
            blankCntReg <= blankCntNext;
            pixCntReg   <= pixCntNext;
            pixLenReg   <= pixLenNext;
            risoModeReg <= risoModeNext;
            shortReg    <= shortNext;
            rowOutReg   <= rowStart;
            loadedReg   <= loadPulse;
            routeValidReg <= routeValidNext;
        end
    end

    assign colBlock       = blockReg;
    assign colHalfLast    = halfReg;
    assign routeValid     = routeValidReg;
    assign lineEnd        = lineEndReg;
    assign rowStartAddr   = rowOutReg;
    assign addrLoaded     = loadedReg;
    assign rowIsolateMode = risoModeReg;
    assign blankTooShort  = shortReg;
    assign lineCycles     = lineLenReg;
    assign pixelCycles    = pixLenReg;

    a_sync_loads_start: assert property (
        syncTaken |=> routeValid && colBlock == $past(colStart)
                      && !colHalfLast)
        else $error("column sync did not load the start block");
    a_rise_first_half: assert property (
        colRise && routeValid |=> !colHalfLast)
        else $error("rising column clock did not select first half");
    a_fall_last_half: assert property (
        colFall && routeValid |=> colHalfLast)
        else $error("falling column clock did not select last half");
    a_no_sync_no_start: assert property (
        !routeValid && !syncTaken |=> !routeValid)
        else $error("scan started without sync on a rising edge");
    a_block_advance: assert property (
        colRise && !syncHigh && routeValid
        && colBlock != `CRSR_LAST_BLOCK
        |=> colBlock == $past(colBlock) + 6'h01)
        else $error("block did not advance on rising edge");
    a_line_end_full: assert property (
        lineEnd |-> $past(colBlock) == `CRSR_LAST_BLOCK
                    && !$past(windowReg))
        else $error("line end outside a full-line scan end");
    a_window_no_end: assert property (
        windowReg && routeValid |=> !lineEnd)
        else $error("line end raised while windowing");
    a_line_time_kept: assert property (
        syncTaken |=> lineCycles == $past(lineCntReg))
        else $error("line time not captured at column sync");
    a_pixel_time_kept: assert property (
        colRise |=> pixelCycles == $past(pixCntReg))
        else $error("pixel period not captured at column edge");
    a_short_blank: assert property (
        syncTaken && blankCntReg < blankMin |=> blankTooShort)
        else $error("short row blanking not flagged");

    c_full_line: cover property (lineEnd);
    c_window_scan: cover property (syncTaken ##1 windowReg);
    c_riso_mode: cover property (rowIsolateMode && syncTaken);
    c_both_halves: cover property (colFall && routeValid ##[1:40] colRise);
endmodule
`default_nettype wire

// ### sim/crsr_seq_model.sv
// Purpose: timing controller model driving column and address pins
// Assumes: column pins move on clk edges; shift clock has its own phase
// Notes: shift clock stands still outside uploads
`default_nettype none
module crsr_seq_model (
    // clock
    input  wire logic clk,
    // address link
    output logic      addrShiftClk,
    output logic      addrIn,
    output logic      addrLoad,
    // column timing
    output logic      colClk,
    output logic      colSync,
    output logic      columnSampleHold,
    output logic      rowIsolate
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PHASE = 6;

    initial begin
        {addrShiftClk, addrIn, addrLoad, colClk, colSync, rowIsolate} = '0;
        columnSampleHold = 1'b1;
    end

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bit0 first so it settles at A1
    task automatic upload(input logic [15:0] word);
        #37.3;
        for (int i = 0; i < 16; i++) begin
            addrIn = word[i];
            #62.5 addrShiftClk = 1'b1;
            #62.5 addrShiftClk = 1'b0;
        end
        addrIn = ~word[15];
        waitClk(2);
        addrLoad <= 1'b1;    // only after all sixteen bits
        waitClk(3);
        addrLoad <= 1'b0;
        waitClk(3);
    endtask

    // blanking, then a sync covering a rise, then p clock phases
    task automatic line(input logic ri, input int blank, input int p);
        @(posedge clk);
        if (!ri && !columnSampleHold) begin
            columnSampleHold <= 1'b1;
            waitClk(3);
        end
        rowIsolate       <= ri;    // no isolate pulse in hold mode
        columnSampleHold <= 1'b0;  // stays low in isolate mode
        waitClk(13);               // shortest whole-cycle pulses
        rowIsolate       <= 1'b0;
        columnSampleHold <= !ri;
        waitClk(blank - 13);
        colSync <= 1'b1;           // high across the rise
        colClk  <= 1'b1;
        for (int k = 1; k < p; k++) begin
            waitClk(PHASE);        // both edges carry pixels
            colSync <= 1'b0;
            colClk  <= ~colClk;
        end
        waitClk(PHASE);
    endtask

    // sync with no rise under it, then a lone rise while idle
    task automatic strayPulse();
        @(posedge clk);
        colSync <= 1'b1;
        waitClk(PHASE);
        colSync <= 1'b0;
        waitClk(PHASE);
        colClk <= 1'b1;
        waitClk(PHASE);
        colClk <= 1'b0;
        waitClk(PHASE);
    endtask
endmodule
`default_nettype wire

// ### sim/crsr_column_readout_tb_top.sv
// Purpose: self-checking bench for the column readout block
// Assumes: pins come from the sequencer model
// Notes: routing changes are matched against queued notes
`include "crsr_cfg.svh"
`default_nettype none
module crsr_column_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        clk;
    logic                        reset;
    logic                        addrShiftClk;
    logic                        addrIn;
    logic                        addrLoad;
    logic                        colClk;
    logic                        colSync;
    logic                        columnSampleHold;
    logic                        rowIsolate;
    logic [`CRSR_COL_BITS-1:0]   colBlock;
    logic                        colHalfLast;
    logic                        routeValid;
    logic                        lineEnd;
    logic [`CRSR_ROW_BITS-1:0]   rowStartAddr;
    logic                        addrLoaded;
    logic                        rowIsolateMode;
    logic                        blankTooShort;
    logic [`CRSR_CNT_BITS-1:0]   lineCycles;
    logic [`CRSR_BLANK_BITS-1:0] pixelCycles;
    logic [7:0]                  routeQ[$];
    logic [9:0]                  addrQ[$];
    logic [7:0]                  prevRoute;
    logic [7:0]                  routeExp;
    logic [9:0]                  addrExp;
    logic [15:0]                 rnd;
    int                          errCount;
    int                          checked;
    int                          endExp;
    int                          endSeen;
    int                          s1;

    crsr_column_readout u_dut (
        .clk(clk), .reset(reset), .addrShiftClk(addrShiftClk),
        .addrIn(addrIn), .addrLoad(addrLoad), .colClk(colClk),
        .colSync(colSync), .columnSampleHold(columnSampleHold),
        .rowIsolate(rowIsolate), .colBlock(colBlock),
        .colHalfLast(colHalfLast), .routeValid(routeValid),
        .lineEnd(lineEnd), .rowStartAddr(rowStartAddr),
        .addrLoaded(addrLoaded), .rowIsolateMode(rowIsolateMode),
        .blankTooShort(blankTooShort), .lineCycles(lineCycles),
        .pixelCycles(pixelCycles));

    crsr_seq_model u_seq (
        .clk(clk), .addrShiftClk(addrShiftClk), .addrIn(addrIn),
        .addrLoad(addrLoad), .colClk(colClk), .colSync(colSync),
        .columnSampleHold(columnSampleHold), .rowIsolate(rowIsolate));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        for (int i = 0; i < 60 && routeQ.size() + addrQ.size() > 0; i++)
            @(posedge clk);
        if (routeQ.size() + addrQ.size() > 0) begin
            errCount++;
            $display("MISMATCH at %0t: expected output never came", $time);
            close_out();
        end
    endtask

    task automatic sendAddr(input logic [5:0] col);
        rnd = lfsr(rnd);
        addrQ.push_back(rnd[9:0]);
        u_seq.upload({col, rnd[9:0]});
        settle();
    endtask

    // notes every routed half; a rise past the last block ends the scan
    task automatic runLine(input logic ri, input int blank, input int s,
                           input int p);
        for (int k = 0; k < p; k++) begin
            if (s + k / 2 > `CRSR_LAST_BLOCK) begin
                routeQ.push_back(8'h00);
                if (s == 0)
                    endExp++;
                break;
            end
            routeQ.push_back({1'b1, 6'(s + k / 2), 1'(k % 2)});
        end
        u_seq.line(ri, blank, p);
    endtask

    always @(posedge clk) begin
        if (!reset) begin
            if (lineEnd === 1'b1)
                endSeen++;
            if ((routeValid || prevRoute[7]) &&
                {routeValid, colBlock, colHalfLast} !== prevRoute) begin
                routeExp = routeQ.size() ? routeQ.pop_front() : 8'hFF;
                if (routeExp[7])
                    check({8'h00, routeValid, colBlock, colHalfLast},
                          {8'h00, routeExp});
                else
                    check({15'h0000, routeValid}, 16'h0000);
            end
            if (addrLoaded === 1'b1) begin
                addrExp = addrQ.size() ? addrQ.pop_front() : 10'h3FF;
                check({6'h00, rowStartAddr},
                      {6'h00, addrExp});
            end
        end
        prevRoute <= {routeValid, colBlock, colHalfLast};
    end

    initial begin
        #100us;
        errCount++;
        $display("MISMATCH at %0t: run did not finish", $time);
        close_out();
    end

    initial begin
        errCount = 0;
        checked = 0;
        endExp = 0;
        endSeen = 0;
        rnd = 16'h5E9B;
        prevRoute = 8'h00;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        sendAddr(6'h00);
        runLine(1'b0, 60, 0, 82);
        settle();
        check({15'h0000, rowIsolateMode}, 16'h0000);
        check({15'h0000, blankTooShort}, 16'h0000);
        u_seq.strayPulse();
        settle();
        check({15'h0000, routeValid}, 16'h0000);
        rnd = lfsr(rnd);
        s1 = int'(rnd % 35) + 1;
        sendAddr(6'(s1));
        runLine(1'b1, 44, s1, 10);
        check({15'h0000, rowIsolateMode}, 16'h0001);
        check({15'h0000, blankTooShort}, 16'h0000);
        // restart mid-line with a blank too short for hold mode
        runLine(1'b0, 44, s1, 2 * (40 - s1) + 2);
        settle();
        check({15'h0000, blankTooShort}, 16'h0001);
        check({15'h0000, rowIsolateMode}, 16'h0000);
        check(lineCycles, 16'h006C);
        check({8'h00, pixelCycles}, 16'h0006);
        check(16'(endSeen), 16'(endExp));
        close_out();
    end
endmodule
`default_nettype wire
